// File: include/ddrtr_pkg.sv
// Package of constants for the DDR2 device-side command timing block
package ddrtr_pkg;
	// ===========================================================
	// Command encodings (cs_n, ras_n, cas_n, we_n)
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_MRS = 4'h0;
	// ===========================================================
	// Address bit that selects auto precharge / precharge all
	localparam int AP_BIT = 10;
	// Bank count and row-active time
	localparam int NBANK = 8;
	localparam int CLK_PS = 10000;
	localparam int TRAS_PS = 40000;
	localparam logic [7:0] TRAS_CYC =
		8'((TRAS_PS + CLK_PS - 1) / CLK_PS);
	// ===========================================================
	// Termination turn-off delay in half clocks (2.5 clocks)
	localparam int AOFD_HALF = 5;
	localparam logic [2:0] AOFD_CYC = 3'(AOFD_HALF / 2);
	// Strobe-to-data groups for the x16 organisation
	localparam int DQ_W = 16;
	localparam int GROUP_W = 8;
	localparam int NGROUP = DQ_W / GROUP_W;
endpackage

// File: src/ddrtr_core.sv
// Device-side DDR2 command timing: row-active lockout, ODT off delay, groups
`timescale 1ns/1ns
// Summary of operation
// - Read or write with auto precharge is accepted before row-active time.
// - Internal precharge is postponed until minimum row-active time passes.
// - Refresh average interval given; bursts allowed, no maximum refresh.
// - Termination starts turning off 2.5 clocks after deassertion; here odt_active falls three clocks after c_odt falls.
// - x16 strobe grouping: lower strobe DQ0-7, upper strobe DQ8-15.
module ddrtr_core
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Command pins, sampled by mclk through two flip-flops
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic [2:0] bank,
	input wire logic ap,
	input wire logic odt,
	// Write data strobes and data, also through two flip-flops
	input wire logic [1:0] dqs,
	input wire logic [15:0] dq,
	// Device state
	output logic [7:0] bank_open,
	output logic [7:0] pre_pending,
	output logic pre_done,
	output logic odt_active,
	output logic [15:0] group_data
);
	// ===========================================================
	// State
	typedef struct packed {
		logic [13:0] s1;
		logic [13:0] s2;
		logic [17:0] w1;
		logic [17:0] w2;
		logic [7:0] open;
		logic [7:0] pend;
		logic [7:0][7:0] age;
		logic done;
		logic term;
		logic [2:0] off_cnt;
		logic [1:0] dqs_q;
		logic [15:0] grp;
	} ddrtr_st_s;

	ddrtr_st_s st;
	ddrtr_st_s next_st;
	logic [3:0] c_cmd;
	logic [2:0] c_bank;
	logic c_ap;
	logic c_odt;
	logic c_cke;
	logic [1:0] c_dqs;
	logic [15:0] c_dq;

	// Unpack the synchronised pins
	assign c_cke = st.s2[13];
	assign c_cmd = st.s2[12:9];
	assign c_bank = st.s2[8:6];
	assign c_ap = st.s2[5];
	assign c_odt = st.s2[4];
	assign c_dqs = st.w2[ddrtr_pkg::DQ_W +: ddrtr_pkg::NGROUP];
	assign c_dq = st.w2[ddrtr_pkg::DQ_W - 1:0];

	// Bank address decode, used for activate, precharge and auto precharge
	function automatic logic [7:0] bank_dec(input logic [2:0] b);
		bank_dec = 8'h01 << b;
	endfunction

	// ===========================================================
	// Next-state logic
	always_comb
	begin
		logic cmd_ok;
		cmd_ok = 1'b0;
		next_st = st;
		next_st.s1 = {cke, cmd, bank, ap, odt, 4'h0};
		next_st.s2 = st.s1;
		// Strobes and data share one pair of flip-flops, so they stay aligned
		next_st.w1 = {dqs, dq};
		next_st.w2 = st.w1;
		next_st.done = 1'b0;
		cmd_ok = c_cke;
		// Row-active age counters per bank
		for (int i = 0; i < ddrtr_pkg::NBANK; i++)
		begin
			if (st.open[i] && st.age[i] != 8'hff)
				next_st.age[i] = st.age[i] + 8'h01;
		end
		// Due precharges wait for row-active time
		// A precharge due too early stays pending and the bank stays open
		for (int i = 0; i < ddrtr_pkg::NBANK; i++)
		begin
			if (st.pend[i] && st.age[i] >= ddrtr_pkg::TRAS_CYC)
			begin
				next_st.pend[i] = 1'b0;
				next_st.open[i] = 1'b0;
				next_st.done = 1'b1;
			end
		end
		if (cmd_ok)
		begin
			case (c_cmd)
				ddrtr_pkg::CMD_ACT:
				begin
					next_st.open = next_st.open | bank_dec(c_bank);
					next_st.age[c_bank] = 8'h01;
				end
				ddrtr_pkg::CMD_RD, ddrtr_pkg::CMD_WR:
					if (c_ap)
						next_st.pend = next_st.pend | bank_dec(c_bank);
				ddrtr_pkg::CMD_PRE:
					if (c_ap)
						next_st.pend = next_st.pend | st.open;
					else
						next_st.pend = next_st.pend |
							(bank_dec(c_bank) & st.open);
				// Refresh and mode commands are taken with no burst limit
				default:
					next_st.pend = next_st.pend;
			endcase
		end
		// Termination: on at once, off three clocks after deassertion
		// A new request restarts the off counter from zero
		if (c_odt)
		begin
			next_st.term = 1'b1;
			next_st.off_cnt = 3'h0;
		end
		else if (st.term)
		begin
			if (st.off_cnt == ddrtr_pkg::AOFD_CYC)
				next_st.term = 1'b0;
			else
				next_st.off_cnt = st.off_cnt + 3'h1;
		end
		// Strobe groups capture their byte lanes from the synchronised pins
		// Either edge of a strobe captures its own lane only
		next_st.dqs_q = c_dqs;
		for (int g = 0; g < ddrtr_pkg::NGROUP; g++)
		begin
			if (c_dqs[g] != st.dqs_q[g])
				next_st.grp[g*ddrtr_pkg::GROUP_W +: ddrtr_pkg::GROUP_W] =
					c_dq[g*ddrtr_pkg::GROUP_W +: ddrtr_pkg::GROUP_W];
		end
	end

	// Register the state
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs straight from flip-flops
	assign bank_open = st.open;
	assign pre_pending = st.pend;
	assign pre_done = st.done;
	assign odt_active = st.term;
	assign group_data = st.grp;

	// ===========================================================
	// Assertions
	sequence odt_fall_s;
		st.term && !c_odt;
	endsequence

	sequence odt_hold_s;
		odt_active [*2];
	endsequence

	tras_lockout_a: assert property (@(posedge mclk) disable iff (reset)
		pre_done |-> $past(pre_pending) != 8'h00)
		else $error("precharge completed with nothing pending");

	pre_age_a: assert property (@(posedge mclk) disable iff (reset)
		(st.pend[0] && st.age[0] < ddrtr_pkg::TRAS_CYC) |=> st.open[0])
		else $error("bank closed before row-active time");

	ap_accept_a: assert property (@(posedge mclk) disable iff (reset)
		(c_cke && c_cmd == ddrtr_pkg::CMD_RD && c_ap && st.open[c_bank])
		|=> st.pend[$past(c_bank)] || !st.open[$past(c_bank)])
		else $error("auto precharge not accepted");

	ap_write_a: assert property (@(posedge mclk) disable iff (reset)
		(c_cke && c_cmd == ddrtr_pkg::CMD_WR && c_ap && st.open[c_bank])
		|=> st.pend[$past(c_bank)] || !st.open[$past(c_bank)])
		else $error("write auto precharge not accepted");

	odt_off_a: assert property (@(posedge mclk) disable iff (reset)
		(odt_fall_s ##1 !c_odt [*3]) |-> !odt_active)
		else $error("termination not off after delay");

	odt_stay_a: assert property (@(posedge mclk) disable iff (reset)
		($fell(c_odt) && st.term) |=> odt_hold_s)
		else $error("termination dropped too early");

	odt_on_a: assert property (@(posedge mclk) disable iff (reset)
		c_odt |=> odt_active)
		else $error("termination not on");

	group_cap_a: assert property (@(posedge mclk) disable iff (reset)
		(c_dqs[1] != st.dqs_q[1]) |=> group_data[15:8] == $past(c_dq[15:8]))
		else $error("upper group not captured");

	group_hold_a: assert property (@(posedge mclk) disable iff (reset)
		(c_dqs[0] == st.dqs_q[0]) |=> $stable(group_data[7:0]))
		else $error("lower group changed without strobe");
endmodule // ddrtr_core

// File: test/ddrtr_ctl.sv
// Controller model that drives the command, termination and data pins
`timescale 1ns/1ns
module ddrtr_ctl
(
	// Clock
	input wire logic mclk,
	// Device pins
	output logic cke,
	output logic [3:0] cmd,
	output logic [2:0] bank,
	output logic ap,
	output logic odt,
	output logic [1:0] dqs,
	output logic [15:0] dq
);
	// Idle pins, clock enable held low through reset
	initial
	begin
		{cke, bank, ap, odt, dqs} = '0;
		cmd = ddrtr_pkg::CMD_NOP;
		dq = 16'h0000;
	end
	// Spacing counts in clocks, picosecond limits rounded up
	localparam int TRP_PS = 15000;
	localparam int TRP_CYC =
		(TRP_PS + ddrtr_pkg::CLK_PS - 1) / ddrtr_pkg::CLK_PS;
	localparam int TRPA_CYC = TRP_CYC + 1;
	localparam int NWR_CYC = 4;
	localparam int TDAL_CYC = NWR_CYC + TRP_CYC;
	localparam int AL_CYC = 0;
	localparam int BL = 4;
	localparam int TRTP_PS = 7500;
	localparam int TRTP_CYC =
		(TRTP_PS + ddrtr_pkg::CLK_PS - 1) / ddrtr_pkg::CLK_PS;
	localparam int RTP_CYC = (TRTP_PS > 2 * ddrtr_pkg::CLK_PS) ?
		TRTP_CYC : AL_CYC + BL / 2;
	localparam int TMOD_CYC = 8;
	localparam int TRRD_CYC = 2;
	localparam int TFAW_CYC = 8;
	// Cycle count and stamps of the last four activates
	int cyc = 0;
	int act_t [4] = '{-1000, -1000, -1000, -1000};
	int act_i = 0;
	always @(posedge mclk)
		cyc++;
	// Change clock enable and hold it for three sampled edges
	task automatic set_cke(input logic v);
		@(negedge mclk);
		cke = v;
		repeat (3) @(negedge mclk);
	endtask
	// One command for one cycle; released lines show the inverse
	task automatic issue(input logic [3:0] c, input logic [2:0] b,
		input logic a);
		@(negedge mclk);
		cmd = c;
		bank = b;
		ap = a;
		@(negedge mclk);
		cmd = ddrtr_pkg::CMD_NOP;
		bank = ~b;
		ap = ~a;
	endtask
	// Termination request level
	task automatic term(input logic v);
		@(negedge mclk);
		odt = v;
	endtask
	// Toggle the strobes in mask m with data d, then release data
	task automatic strobe(input logic [1:0] m, input logic [15:0] d);
		@(negedge mclk);
		dq = d;
		dqs = dqs ^ m;
		@(negedge mclk);
		dq = ~d;
	endtask
	// Activate after the activate spacing and the four-activate window
	task automatic activate(input logic [2:0] b);
		while (cyc - act_t[(act_i + 3) % 4] < TRRD_CYC ||
			cyc - act_t[act_i] < TFAW_CYC)
			@(negedge mclk);
		issue(ddrtr_pkg::CMD_ACT, b, 1'b0);
		act_t[act_i] = cyc;
		act_i = (act_i + 1) % 4;
	endtask
	// Recovery wait that the controller owes after a command
	task automatic recover(input logic [3:0] c, input logic a);
		int n;
		n = 0;
		case (c)
			ddrtr_pkg::CMD_PRE: n = a ? TRPA_CYC : TRP_CYC;
			ddrtr_pkg::CMD_WR: n = a ? TDAL_CYC : 0;
			ddrtr_pkg::CMD_RD: n = RTP_CYC;
			ddrtr_pkg::CMD_MRS: n = TMOD_CYC;
			default: n = 0;
		endcase
		repeat (n) @(negedge mclk);
	endtask
	// Burst of refreshes; the average rate still gives 8192 per interval
	task automatic refresh(input int n);
		repeat (n) issue(ddrtr_pkg::CMD_REF, 3'h0, 1'b0);
	endtask
endmodule // ddrtr_ctl

// File: test/ddrtr_core_tb.sv
// Self-checking testbench of the device-side command timing block
`timescale 1ns/1ns
module ddrtr_core_tb;
	logic mclk, reset, cke, ap, odt;
	logic [3:0] cmd;
	logic [2:0] bank;
	logic [1:0] dqs;
	logic [15:0] dq, group_data;
	logic [7:0] bank_open, pre_pending;
	logic pre_done, odt_active;
	int error_cnt = 0;
	int num_checks = 0;
	int cycles = 0;
	ddrtr_ctl ctl (.mclk(mclk), .cke(cke), .cmd(cmd), .bank(bank), .ap(ap),
		.odt(odt), .dqs(dqs), .dq(dq));
	ddrtr_core uut (.mclk(mclk), .reset(reset), .cke(cke), .cmd(cmd),
		.bank(bank), .ap(ap), .odt(odt), .dqs(dqs), .dq(dq),
		.bank_open(bank_open), .pre_pending(pre_pending),
		.pre_done(pre_done), .odt_active(odt_active),
		.group_data(group_data));
	// Clock and hang limit
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			error_cnt++;
			conclude();
		end
	end
	// Compare one value
	task automatic check(input string what, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Read with auto precharge right after activate waits for row time
	task automatic t_lockout();
		int n;
		ctl.activate(3'h2);
		ctl.issue(ddrtr_pkg::CMD_RD, 3'h2, 1'b1);
		repeat (3) @(negedge mclk);
		check("pending", 16'h0004, {8'h00, pre_pending});
		check("open", 16'h0004, {8'h00, bank_open});
		for (n = 0; n < 10 && pre_done !== 1'b1; n++)
			@(negedge mclk);
		check("done", 16'h0001, {15'h0000, pre_done});
		@(negedge mclk);
		check("closed", 16'h0000, {pre_pending, bank_open});
	endtask
	// Activate ignored with clock enable low, precharge ignored on a closed bank
	task automatic t_refuse();
		ctl.set_cke(1'b0);
		ctl.issue(ddrtr_pkg::CMD_ACT, 3'h6, 1'b0);
		repeat (4) @(negedge mclk);
		check("cke low", 16'h0000, {8'h00, bank_open});
		ctl.set_cke(1'b1);
		ctl.issue(ddrtr_pkg::CMD_PRE, 3'h5, 1'b0);
		repeat (4) @(negedge mclk);
		check("pre closed", 16'h0000, {pre_pending, pre_done, 7'h00});
	endtask
	// Termination stays on four clocks after release and is off on the fifth
	task automatic t_odt();
		ctl.issue(ddrtr_pkg::CMD_MRS, 3'h0, 1'b0);
		ctl.recover(ddrtr_pkg::CMD_MRS, 1'b0);
		ctl.term(1'b1);
		repeat (6) @(negedge mclk);
		check("odt on", 16'h0001, {15'h0000, odt_active});
		ctl.term(1'b0);
		repeat (4) @(negedge mclk);
		check("odt hold", 16'h0001, {15'h0000, odt_active});
		@(negedge mclk);
		check("odt off", 16'h0000, {15'h0000, odt_active});
	endtask
	// Each strobe captures only its own byte lane
	task automatic t_group();
		ctl.strobe(2'b01, 16'h1234);
		ctl.strobe(2'b10, 16'habcd);
		repeat (3) @(negedge mclk);
		check("lanes", 16'hab34, group_data);
	endtask
	// Precharge-all after a read closes every open bank
	task automatic t_prech_all();
		int n;
		ctl.activate(3'h1);
		ctl.activate(3'h3);
		ctl.issue(ddrtr_pkg::CMD_RD, 3'h1, 1'b0);
		ctl.recover(ddrtr_pkg::CMD_RD, 1'b0);
		check("open pair", 16'h000a, {8'h00, bank_open});
		ctl.issue(ddrtr_pkg::CMD_PRE, 3'h0, 1'b1);
		for (n = 0; n < 10 && pre_done !== 1'b1; n++)
			@(negedge mclk);
		check("all done", 16'h0001, {15'h0000, pre_done});
		@(negedge mclk);
		check("all closed", 16'h0000, {pre_pending, bank_open});
		ctl.recover(ddrtr_pkg::CMD_PRE, 1'b1);
	endtask
	// Write with auto precharge right after activate waits for row time
	task automatic t_write_ap();
		int n;
		ctl.activate(3'h4);
		ctl.issue(ddrtr_pkg::CMD_WR, 3'h4, 1'b1);
		repeat (3) @(negedge mclk);
		check("wr lockout", 16'h1010, {pre_pending, bank_open});
		for (n = 0; n < 10 && pre_done !== 1'b1; n++)
			@(negedge mclk);
		check("wr done", 16'h0001, {15'h0000, pre_done});
		@(negedge mclk);
		check("wr closed", 16'h0000, {pre_pending, bank_open});
		ctl.recover(ddrtr_pkg::CMD_WR, 1'b1);
	endtask
	// Refresh burst opens nothing and leaves nothing pending
	task automatic t_refresh();
		ctl.refresh(4);
		repeat (4) @(negedge mclk);
		check("refresh", 16'h0000, {pre_pending, bank_open});
		check("ref done", 16'h0000, {15'h0000, pre_done});
	endtask
	// Main sequence
	initial
	begin
		reset = 1'b1;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		check("reset", 16'h0000, {bank_open, pre_pending});
		ctl.set_cke(1'b1);
		t_lockout();
		t_refuse();
		t_prech_all();
		t_write_ap();
		t_refresh();
		t_odt();
		t_group();
		conclude();
	end
endmodule // ddrtr_core_tb
